// ---- rtl/smpm_map.svh ----
// Purpose: constants for switch-mode init and port-merge block
// Assumes: sixteen ports, sixteen partitions, eight mergeable pairs
// Notes:   field widths of state and mode fields are local choices
`ifndef SMPM_MAP_SVH
`define SMPM_MAP_SVH

`define SMPM_NPORTS      16
`define SMPM_NPAIRS      8
`define SMPM_NPARTS      16
`define SMPM_SWM_W       4
`define SMPM_STATE_W     3
`define SMPM_MODE_W      4
`define SMPM_LANE_W      5
`define SMPM_IDX_W       4
`define SMPM_PORT_LANES  5'h04

// switch-mode strap codes
`define SMPM_SWM_SINGLE     4'h0
`define SMPM_SWM_SINGLE_EE  4'h1
`define SMPM_SWM_P0UP       4'h8
`define SMPM_SWM_P2UP       4'h9
`define SMPM_SWM_P0UP_EE    4'hA
`define SMPM_SWM_P2UP_EE    4'hB
`define SMPM_SWM_MULTI      4'hC
`define SMPM_SWM_MULTI_EE   4'hD

// partition state and port operating-mode values
`define SMPM_PART_DISABLED  3'h0
`define SMPM_PART_ACTIVE    3'h1
`define SMPM_PMODE_DISABLED 4'h0
`define SMPM_PMODE_DOWN     4'h1
`define SMPM_PMODE_UP       4'h2
`define SMPM_PMODE_UNATT    4'h5

`define SMPM_PORT0          0
`define SMPM_PORT2          2
`define SMPM_PART0          0

`endif

// ---- rtl/smpm_pkg.sv ----
// Purpose: types for switch-mode init and port-merge block
// Assumes: smpm_map.svh gives every width except the two-bit phase
// Notes:   smpm_top state outside the synchronisers is one packed struct
`include "smpm_map.svh"

package smpm_pkg;

  typedef enum logic [1:0] {
    SMPM_ST_RESET,
    SMPM_ST_APPLY,
    SMPM_ST_RUN
  } smpm_phase_t;

  typedef struct packed {
    smpm_phase_t                                   phase;
    logic                                          done;
    logic [`SMPM_SWM_W-1:0]                        switch_mode_strap;
    logic                                          test_mode;
    logic                                          eeprom_start;
    logic [`SMPM_NPAIRS-1:0]                       merged;
    logic [`SMPM_NPORTS-1:0]                       deact;
    logic [`SMPM_NPARTS*`SMPM_STATE_W-1:0]         part_state;
    logic [`SMPM_NPORTS*`SMPM_MODE_W-1:0]          port_mode;
    logic [`SMPM_NPORTS*`SMPM_LANE_W-1:0]          width;
    logic [`SMPM_NPORTS-1:0]                       link_en;
    logic [`SMPM_NPORTS-1:0]                       part_member;
    logic [`SMPM_NPORTS-1:0]                       low_power;
    logic [`SMPM_NPORTS-1:0]                       attn_ind;
    logic [`SMPM_NPORTS-1:0]                       ilock;
    logic [`SMPM_NPORTS-1:0]                       pwr_en;
    logic [`SMPM_NPORTS-1:0]                       pwr_ind;
    logic [`SMPM_NPORTS-1:0]                       rst_n;
    logic [`SMPM_NPORTS-1:0]                       act_n;
    logic [`SMPM_NPORTS-1:0]                       lnk_n;
    logic [`SMPM_NPORTS-1:0]                       btn_n;
    logic [`SMPM_NPORTS-1:0]                       mrl_n;
    logic [`SMPM_NPORTS-1:0]                       pres_n;
    logic [`SMPM_NPORTS-1:0]                       pfault_n;
    logic [`SMPM_NPORTS-1:0]                       pgood_n;
  } smpm_state_t;

endpackage : smpm_pkg

// ---- rtl/smpm_sync.sv ----
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to core_clk
// Notes:   output changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module smpm_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] din,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } smpm_sync_t;

  smpm_sync_t s_q;
  smpm_sync_t s_d;

  // stage one feeds stage two only; the filter looks at two and three
  always_comb begin
    s_d    = s_q;
    // stages hold pin xor rst_val, so a cleared flop reads as rst_val
    s_d.s1 = din ^ rst_val;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.filt[i] = s_q.s3[i];
      end
    end
  end

  // rst_val is a tie-off constant, so the first samples hold it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.filt ^ rst_val;

endmodule : smpm_sync

`default_nettype wire

// ---- rtl/smpm_top.sv ----
// Purpose: switch-mode dependent init and port merging at fundamental reset
// Assumes: SW_FUND_RESET comes from core-clock logic; straps are pins
// Notes:   hot-plug pins pass three sync flops and a filter flop before use
//
// Summary of operation
// - only eight listed single/multi/upstream modes are normal; rest are test
// - mode-dependent initial fields load at end of fundamental reset
// - eeprom and non-eeprom variants give same config, only load differs
// - mode 0/1: part0 active, others off, port0 upstream, rest down
// - mode 8/A: part0 active, port0 upstream, port2 disabled, rest down
// - mode 9/B: part0 active, port2 upstream, port0 disabled, rest down
// - mode C/D: all partitions off, all ports unattached, partitioning open
// - single-partition modes block config of partitions other than zero
// - merging only joins an even port with the next odd port
// - active-low pair straps sampled during fundamental reset; low merges
// - merge choice holds until next fundamental reset
// - merged port link width is sum of both port widths
// - merged pair: even port stays active, odd port deactivated
// - deactivated port drives all outputs negated, incl activity and linkup
// - deactivated port ignores all its inputs incl hot-plug inputs
// - deactivated port has no link and is outside the hierarchy
// - deactivated port belongs to no partition
// - deactivated port logic goes to low power
// - deactivated port registers stay reachable in global space
// - deactivation holds whatever the port mode field says
// - after reset, operation follows the held switch-mode value
`timescale 1ns/1ps
`default_nettype none
`include "smpm_map.svh"

module smpm_top #(
  parameter logic NEG_ATTN_IND = 1'b0,
  parameter logic NEG_ILOCK    = 1'b0,
  parameter logic NEG_PWR_EN   = 1'b0,
  parameter logic NEG_PWR_IND  = 1'b0,
  parameter logic NEG_RST_N    = 1'b0
) (
  input  wire logic                                   CORE_CLK,
  input  wire logic                                   RST_B,
  input  wire logic                                   CLK_EN,
  input  wire logic                                   SW_FUND_RESET,
  input  wire logic [`SMPM_SWM_W-1:0]                 SWITCH_MODE_STRAP,
  input  wire logic [`SMPM_NPAIRS-1:0]                PAIR_MERGE_STRAP_N,
  input  wire logic                                   CFG_PART_WE,
  input  wire logic [`SMPM_IDX_W-1:0]                 CFG_PART_IDX,
  input  wire logic [`SMPM_STATE_W-1:0]               CFG_PART_DATA,
  input  wire logic                                   CFG_PORT_WE,
  input  wire logic [`SMPM_IDX_W-1:0]                 CFG_PORT_IDX,
  input  wire logic [`SMPM_MODE_W-1:0]                CFG_PORT_DATA,
  input  wire logic [`SMPM_NPORTS-1:0]                CORE_ATTN_IND,
  input  wire logic [`SMPM_NPORTS-1:0]                CORE_ILOCK,
  input  wire logic [`SMPM_NPORTS-1:0]                CORE_PWR_EN,
  input  wire logic [`SMPM_NPORTS-1:0]                CORE_PWR_IND,
  input  wire logic [`SMPM_NPORTS-1:0]                CORE_PORT_RST_N,
  input  wire logic [`SMPM_NPORTS-1:0]                CORE_ACTIVE,
  input  wire logic [`SMPM_NPORTS-1:0]                CORE_LINKUP,
  input  wire logic [`SMPM_NPORTS-1:0]                ATTENTION_BUTTON_IN_N,
  input  wire logic [`SMPM_NPORTS-1:0]                LATCH_SENSOR_IN_N,
  input  wire logic [`SMPM_NPORTS-1:0]                PRESENCE_DETECT_IN_N,
  input  wire logic [`SMPM_NPORTS-1:0]                POWER_FAULT_IN_N,
  input  wire logic [`SMPM_NPORTS-1:0]                POWER_GOOD_IN_N,
  output logic                                        CONFIG_DONE,
  output logic                                        TEST_MODE,
  output logic                                        EEPROM_LOAD_START,
  output logic [`SMPM_SWM_W-1:0]                      SWITCH_MODE,
  output logic [`SMPM_NPAIRS-1:0]                     PAIR_MERGED,
  output logic [`SMPM_NPORTS-1:0]                     PORT_DEACTIVATED,
  output logic [`SMPM_NPARTS*`SMPM_STATE_W-1:0]       PARTITION_CONTROL,
  output logic [`SMPM_NPORTS*`SMPM_MODE_W-1:0]        PORT_CONTROL,
  output logic [`SMPM_NPORTS*`SMPM_LANE_W-1:0]        PORT_LINK_WIDTH,
  output logic [`SMPM_NPORTS-1:0]                     PORT_LINK_EN,
  output logic [`SMPM_NPORTS-1:0]                     PORT_PART_MEMBER,
  output logic [`SMPM_NPORTS-1:0]                     PORT_LOW_POWER,
  output logic [`SMPM_NPORTS-1:0]                     ATTENTION_INDICATOR_OUT,
  output logic [`SMPM_NPORTS-1:0]                     INTERLOCK_OUT,
  output logic [`SMPM_NPORTS-1:0]                     POWER_ENABLE_OUT,
  output logic [`SMPM_NPORTS-1:0]                     POWER_INDICATOR_OUT,
  output logic [`SMPM_NPORTS-1:0]                     PORT_RESET_OUT_N,
  output logic [`SMPM_NPORTS-1:0]                     PORT_ACTIVITY_OUT_N,
  output logic [`SMPM_NPORTS-1:0]                     PORT_LINKUP_OUT_N,
  output logic [`SMPM_NPORTS-1:0]                     CORE_ATTN_BTN_N,
  output logic [`SMPM_NPORTS-1:0]                     CORE_LATCH_N,
  output logic [`SMPM_NPORTS-1:0]                     CORE_PRESENCE_N,
  output logic [`SMPM_NPORTS-1:0]                     CORE_PWR_FAULT_N,
  output logic [`SMPM_NPORTS-1:0]                     CORE_PWR_GOOD_N
);
  import smpm_pkg::*;

  localparam int NP   = `SMPM_NPORTS;
  localparam int NPR  = `SMPM_NPAIRS;
  localparam int NPT  = `SMPM_NPARTS;
  localparam int SW   = `SMPM_STATE_W;
  localparam int MW   = `SMPM_MODE_W;
  localparam int LW   = `SMPM_LANE_W;
  localparam int HPW  = 5 * NP;
  localparam int STW  = `SMPM_SWM_W + NPR;

  // active-low pins reset to negated so nothing looks asserted at power-up
  localparam smpm_state_t S_RST = '{
    phase: SMPM_ST_RESET, act_n: '1, lnk_n: '1, btn_n: '1, mrl_n: '1,
    pres_n: '1, pfault_n: '1, pgood_n: '1, rst_n: '1, default: '0};

  //////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_normal(input logic [`SMPM_SWM_W-1:0] m);
    unique case (m)
      `SMPM_SWM_SINGLE, `SMPM_SWM_SINGLE_EE,
      `SMPM_SWM_P0UP, `SMPM_SWM_P0UP_EE,
      `SMPM_SWM_P2UP, `SMPM_SWM_P2UP_EE,
      `SMPM_SWM_MULTI, `SMPM_SWM_MULTI_EE: is_normal = 1'b1;
      default: is_normal = 1'b0;
    endcase
  endfunction : is_normal

  function automatic logic uses_eeprom(input logic [`SMPM_SWM_W-1:0] m);
    uses_eeprom = (m == `SMPM_SWM_SINGLE_EE) || (m == `SMPM_SWM_P0UP_EE) ||
                  (m == `SMPM_SWM_P2UP_EE) || (m == `SMPM_SWM_MULTI_EE);
  endfunction : uses_eeprom

  function automatic logic is_single(input logic [`SMPM_SWM_W-1:0] m);
    is_single = is_normal(m) && (m != `SMPM_SWM_MULTI) &&
                (m != `SMPM_SWM_MULTI_EE);
  endfunction : is_single

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: mode and merge straps, then hot-plug inputs

  logic [STW-1:0] strap_s;
  logic [HPW-1:0] hp_in_s;

  smpm_sync #(.W(STW)) u_strap_sync (
    .core_clk (CORE_CLK),
    .rst_b    (RST_B),
    .clk_en   (CLK_EN),
    .din      ({SWITCH_MODE_STRAP, PAIR_MERGE_STRAP_N}),
    .rst_val  ({{`SMPM_SWM_W{1'b0}}, {NPR{1'b1}}}),
    .dout     (strap_s)
  );

  // xor with ones keeps the idle-high hot-plug pins negated after reset
  smpm_sync #(.W(HPW)) u_hp_sync (
    .core_clk (CORE_CLK),
    .rst_b    (RST_B),
    .clk_en   (CLK_EN),
    .din      ({ATTENTION_BUTTON_IN_N, LATCH_SENSOR_IN_N,
                PRESENCE_DETECT_IN_N, POWER_FAULT_IN_N, POWER_GOOD_IN_N}),
    .rst_val  ({HPW{1'b1}}),
    .dout     (hp_in_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state

  smpm_state_t s_q;
  smpm_state_t s_d;
  logic [MW-1:0] mode_tbl [NP];
  logic [SW-1:0] part_tbl [NPT];
  logic          part_wr_ok;

  // initial field table for the held switch mode; eeprom variants
  // fall through to the same entries as their plain twins
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      mode_tbl[p] = `SMPM_PMODE_DOWN;
    end
    for (int t = 0; t < NPT; t++) begin
      part_tbl[t] = `SMPM_PART_DISABLED;
    end
    case (s_q.switch_mode_strap)
      `SMPM_SWM_SINGLE, `SMPM_SWM_SINGLE_EE: begin
        part_tbl[`SMPM_PART0] = `SMPM_PART_ACTIVE;
        mode_tbl[`SMPM_PORT0] = `SMPM_PMODE_UP;
      end
      `SMPM_SWM_P0UP, `SMPM_SWM_P0UP_EE: begin
        part_tbl[`SMPM_PART0] = `SMPM_PART_ACTIVE;
        mode_tbl[`SMPM_PORT0] = `SMPM_PMODE_UP;
        mode_tbl[`SMPM_PORT2] = `SMPM_PMODE_DISABLED;
      end
      `SMPM_SWM_P2UP, `SMPM_SWM_P2UP_EE: begin
        part_tbl[`SMPM_PART0] = `SMPM_PART_ACTIVE;
        mode_tbl[`SMPM_PORT2] = `SMPM_PMODE_UP;
        mode_tbl[`SMPM_PORT0] = `SMPM_PMODE_DISABLED;
      end
      `SMPM_SWM_MULTI, `SMPM_SWM_MULTI_EE: begin
        for (int p = 0; p < NP; p++) begin
          mode_tbl[p] = `SMPM_PMODE_UNATT;
        end
      end
      default: begin
        // test modes keep the single-partition defaults
        part_tbl[`SMPM_PART0] = `SMPM_PART_ACTIVE;
        mode_tbl[`SMPM_PORT0] = `SMPM_PMODE_UP;
      end
    endcase
  end

  // multi-partition and test modes leave every partition writable
  assign part_wr_ok = !is_single(s_q.switch_mode_strap) ||
                      (CFG_PART_IDX == `SMPM_IDX_W'(`SMPM_PART0));

  always_comb begin
    logic [MW-1:0] pm;
    pm = '0;
    s_d = s_q;
    s_d.eeprom_start = 1'b0;
    case (s_q.phase)
      SMPM_ST_RESET: begin
        // straps follow the pins only while reset is asserted
        s_d.switch_mode_strap = strap_s[STW-1 -: `SMPM_SWM_W];
        s_d.merged = ~strap_s[NPR-1:0];
        if (!SW_FUND_RESET) begin
          s_d.phase = SMPM_ST_APPLY;
        end
      end
      SMPM_ST_APPLY: begin
        for (int p = 0; p < NP; p++) begin
          s_d.port_mode[p*MW +: MW] = mode_tbl[p];
        end
        for (int t = 0; t < NPT; t++) begin
          s_d.part_state[t*SW +: SW] = part_tbl[t];
        end
        s_d.test_mode    = !is_normal(s_q.switch_mode_strap);
        s_d.eeprom_start = uses_eeprom(s_q.switch_mode_strap);
        s_d.phase        = SMPM_ST_RUN;
      end
      SMPM_ST_RUN: begin
        // switch_mode_strap and merged are frozen here until the next reset
        if (CFG_PART_WE && part_wr_ok) begin
          s_d.part_state[CFG_PART_IDX*SW +: SW] = CFG_PART_DATA;
        end
        // mode writes land even on a deactivated port; it stays off
        if (CFG_PORT_WE) begin
          s_d.port_mode[CFG_PORT_IDX*MW +: MW] = CFG_PORT_DATA;
        end
      end
      default: s_d.phase = SMPM_ST_RESET;
    endcase
    if (SW_FUND_RESET) begin
      s_d.phase = SMPM_ST_RESET;
    end
    s_d.done = (s_d.phase == SMPM_ST_RUN);

    // per-port gating from the current merge state
    for (int i = 0; i < NPR; i++) begin
      s_d.deact[2*i]   = 1'b0;
      s_d.deact[2*i+1] = s_q.merged[i];
      s_d.width[2*i*LW +: LW] = s_q.merged[i] ?
          LW'(`SMPM_PORT_LANES << 1) : `SMPM_PORT_LANES;
      s_d.width[(2*i+1)*LW +: LW] = s_q.merged[i] ? '0 : `SMPM_PORT_LANES;
    end
    for (int p = 0; p < NP; p++) begin
      pm = s_q.port_mode[p*MW +: MW];
      if (s_q.deact[p]) begin
        s_d.attn_ind[p] = NEG_ATTN_IND;
        s_d.ilock[p]    = NEG_ILOCK;
        s_d.pwr_en[p]   = NEG_PWR_EN;
        s_d.pwr_ind[p]  = NEG_PWR_IND;
        s_d.rst_n[p]    = NEG_RST_N;
        s_d.act_n[p]    = 1'b1;
        s_d.lnk_n[p]    = 1'b1;
        s_d.btn_n[p]    = 1'b1;
        s_d.mrl_n[p]    = 1'b1;
        s_d.pres_n[p]   = 1'b1;
        s_d.pfault_n[p] = 1'b1;
        s_d.pgood_n[p]  = 1'b1;
      end else begin
        s_d.attn_ind[p] = CORE_ATTN_IND[p];
        s_d.ilock[p]    = CORE_ILOCK[p];
        s_d.pwr_en[p]   = CORE_PWR_EN[p];
        s_d.pwr_ind[p]  = CORE_PWR_IND[p];
        s_d.rst_n[p]    = CORE_PORT_RST_N[p];
        s_d.act_n[p]    = !CORE_ACTIVE[p];
        s_d.lnk_n[p]    = !CORE_LINKUP[p];
        s_d.btn_n[p]    = hp_in_s[4*NP + p];
        s_d.mrl_n[p]    = hp_in_s[3*NP + p];
        s_d.pres_n[p]   = hp_in_s[2*NP + p];
        s_d.pfault_n[p] = hp_in_s[NP + p];
        s_d.pgood_n[p]  = hp_in_s[p];
      end
      // deactivation wins over whatever the mode field holds
      s_d.link_en[p] = !s_q.deact[p] && (s_q.phase == SMPM_ST_RUN) &&
                       (pm != `SMPM_PMODE_DISABLED);
      s_d.part_member[p] = !s_q.deact[p] && (pm != `SMPM_PMODE_DISABLED) &&
                           (pm != `SMPM_PMODE_UNATT);
      s_d.low_power[p] = s_q.deact[p];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= S_RST;
    end else if (CLK_EN) begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, each a field of the state register

  assign CONFIG_DONE         = s_q.done;
  assign TEST_MODE           = s_q.test_mode;
  assign EEPROM_LOAD_START   = s_q.eeprom_start;
  assign SWITCH_MODE         = s_q.switch_mode_strap;
  assign PAIR_MERGED         = s_q.merged;
  assign PORT_DEACTIVATED    = s_q.deact;
  assign PARTITION_CONTROL   = s_q.part_state;
  assign PORT_CONTROL        = s_q.port_mode;
  assign PORT_LINK_WIDTH     = s_q.width;
  assign PORT_LINK_EN        = s_q.link_en;
  assign PORT_PART_MEMBER    = s_q.part_member;
  assign PORT_LOW_POWER      = s_q.low_power;
  assign ATTENTION_INDICATOR_OUT = s_q.attn_ind;
  assign INTERLOCK_OUT       = s_q.ilock;
  assign POWER_ENABLE_OUT    = s_q.pwr_en;
  assign POWER_INDICATOR_OUT = s_q.pwr_ind;
  assign PORT_RESET_OUT_N    = s_q.rst_n;
  assign PORT_ACTIVITY_OUT_N = s_q.act_n;
  assign PORT_LINKUP_OUT_N   = s_q.lnk_n;
  assign CORE_ATTN_BTN_N     = s_q.btn_n;
  assign CORE_LATCH_N        = s_q.mrl_n;
  assign CORE_PRESENCE_N     = s_q.pres_n;
  assign CORE_PWR_FAULT_N    = s_q.pfault_n;
  assign CORE_PWR_GOOD_N     = s_q.pgood_n;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  sequence run_steady;
    (s_q.phase == SMPM_ST_RUN) ##1 (s_q.phase == SMPM_ST_RUN);
  endsequence

  merge_hold_a: assert property (run_steady |-> $stable(s_q.merged) &&
    $stable(s_q.switch_mode_strap)) else $error("merge or mode changed outside reset");

  eeprom_only_a: assert property (EEPROM_LOAD_START |->
    CONFIG_DONE && uses_eeprom(s_q.switch_mode_strap))
    else $error("eeprom load started in wrong mode");

  test_flag_a: assert property (CONFIG_DONE |->
    TEST_MODE == !is_normal(s_q.switch_mode_strap)) else $error("test mode flag wrong");

  multi_init_a: assert property (CLK_EN && !SW_FUND_RESET &&
    s_q.phase == SMPM_ST_APPLY &&
    (s_q.switch_mode_strap == `SMPM_SWM_MULTI || s_q.switch_mode_strap == `SMPM_SWM_MULTI_EE)
    |=> PORT_CONTROL == {NP{`SMPM_PMODE_UNATT}} && PARTITION_CONTROL == '0)
    else $error("multi-partition init wrong");

  p2up_init_a: assert property (CLK_EN && !SW_FUND_RESET &&
    s_q.phase == SMPM_ST_APPLY && s_q.switch_mode_strap == `SMPM_SWM_P2UP |=>
    PORT_CONTROL[`SMPM_PORT2*MW +: MW] == `SMPM_PMODE_UP &&
    PORT_CONTROL[`SMPM_PORT0*MW +: MW] == `SMPM_PMODE_DISABLED)
    else $error("port 2 upstream init wrong");

  part_lock_a: assert property (CLK_EN && !SW_FUND_RESET && CONFIG_DONE &&
    is_single(s_q.switch_mode_strap) && CFG_PART_WE && CFG_PART_IDX != '0 |=>
    $stable(PARTITION_CONTROL)) else $error("partition write not blocked");

  genvar g;
  generate
    for (g = 0; g < NPR; g++) begin : g_pair_chk
      pair_deact_a: assert property (CLK_EN && s_q.merged[g] &&
        !SW_FUND_RESET ##1 CLK_EN |=> PORT_DEACTIVATED[2*g+1] &&
        !PORT_DEACTIVATED[2*g]) else $error("pair deactivation wrong");
      odd_negated_a: assert property (PORT_DEACTIVATED[2*g+1] && CLK_EN
        |=> PORT_LINKUP_OUT_N[2*g+1] && PORT_ACTIVITY_OUT_N[2*g+1] &&
        CORE_PRESENCE_N[2*g+1] && !PORT_LINK_EN[2*g+1] &&
        PORT_LOW_POWER[2*g+1]) else $error("deactivated port not quiet");
      sum_width_a: assert property (PAIR_MERGED[g] && CLK_EN
        |=> PORT_LINK_WIDTH[2*g*LW +: LW] == LW'(`SMPM_PORT_LANES << 1))
        else $error("merged width is not the sum");
    end
  endgenerate

endmodule : smpm_top

`default_nettype wire

// ---- test/smpm_strap_model.sv ----
// Purpose: board straps and fundamental reset source for smpm_top
// Assumes: GO is a one-cycle request from the bench
// Notes:   straps wander after reset drops, to prove they are ignored
`timescale 1ns/1ps
`default_nettype none
module smpm_strap_model (
  input  wire logic       CORE_CLK,
  input  wire logic       GO,
  input  wire logic [3:0] MODE_IN,
  input  wire logic [7:0] MERGE_N_IN,
  output logic            SW_FUND_RESET,
  output logic [3:0]      SWITCH_MODE_STRAP,
  output logic [7:0]      PAIR_MERGE_STRAP_N
);
  int cnt_q = 0;
  initial begin
    // held from power-up so no config run starts before the first straps
    SW_FUND_RESET = 1'b1;
    SWITCH_MODE_STRAP = 4'h0;
    PAIR_MERGE_STRAP_N = 8'hFF;
  end
  //////////////////////////////////////////////////////////////////////////
  always @(posedge CORE_CLK) begin
    if (GO) begin
      SWITCH_MODE_STRAP <= MODE_IN;
      PAIR_MERGE_STRAP_N <= MERGE_N_IN;
      SW_FUND_RESET <= 1'b1;
      cnt_q <= 10;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
      // held long enough for three sync flops and the sample
      if (cnt_q == 3) SW_FUND_RESET <= 1'b0;
      if (cnt_q == 1) begin
        SWITCH_MODE_STRAP <= ~SWITCH_MODE_STRAP;
        PAIR_MERGE_STRAP_N <= ~PAIR_MERGE_STRAP_N;
      end
    end
  end
endmodule : smpm_strap_model
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: self-checking bench for smpm_top, all sixteen mode codes
// Assumes: core side held high so gated ports stand out
// Notes:   expectations queued by driver, popped on output change
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [63:0] pc;
    logic [47:0] pa;
    logic [15:0] dm;
    logic [1:0]  te;
    logic [11:0] sp;
  } smpm_exp_t;
  smpm_exp_t q[$];
  smpm_exp_t e;
  smpm_exp_t le;
  logic CORE_CLK = 1'b0, RST_B = 1'b0, go = 1'b0, CFG_PART_WE = 1'b0;
  logic CFG_PORT_WE = 1'b0, SW_FUND_RESET, CONFIG_DONE, TEST_MODE, ee, pd;
  logic [3:0] md = 4'h0, CFG_PART_IDX = 4'h0, CFG_PORT_IDX = 4'h0, sm;
  logic [3:0] CFG_PORT_DATA = 4'h0;
  logic [2:0] CFG_PART_DATA = 3'h0;
  logic [7:0] mg = 8'hFF, PAIR_MERGE_STRAP_N;
  logic [15:0] on = '1, zr = '0, dact, lp, lke, mem, act_n, attn, pres_n;
  logic [15:0] il, pe, pi, rn, lnk;
  logic [3:0] swm;
  logic [7:0] pmg;
  logic [47:0] PARTITION_CONTROL, ppa;
  logic [63:0] PORT_CONTROL, ppc;
  logic [79:0] wid;
  int bad_count = 0, n_tests = 0, lk = 0;
  always #5 CORE_CLK = ~CORE_CLK;
  smpm_strap_model pm (.CORE_CLK, .GO(go), .MODE_IN(md), .MERGE_N_IN(mg),
    .SW_FUND_RESET, .SWITCH_MODE_STRAP(sm), .PAIR_MERGE_STRAP_N);
  smpm_top dut (.CORE_CLK, .RST_B, .CLK_EN(1'b1), .SW_FUND_RESET,
    .SWITCH_MODE_STRAP(sm), .PAIR_MERGE_STRAP_N, .CFG_PART_WE, .CFG_PART_IDX,
    .CFG_PART_DATA, .CFG_PORT_WE, .CFG_PORT_IDX, .CFG_PORT_DATA,
    .CORE_ATTN_IND(on), .CORE_ILOCK(on), .CORE_PWR_EN(on), .CORE_PWR_IND(on),
    .CORE_PORT_RST_N(on), .CORE_ACTIVE(on), .CORE_LINKUP(on),
    .ATTENTION_BUTTON_IN_N(zr), .LATCH_SENSOR_IN_N(zr),
    .PRESENCE_DETECT_IN_N(zr), .POWER_FAULT_IN_N(zr), .POWER_GOOD_IN_N(zr),
    .CONFIG_DONE, .TEST_MODE, .EEPROM_LOAD_START(ee), .SWITCH_MODE(swm),
    .PAIR_MERGED(pmg), .PORT_DEACTIVATED(dact), .PARTITION_CONTROL,
    .PORT_CONTROL, .PORT_LINK_WIDTH(wid), .PORT_LINK_EN(lke),
    .PORT_PART_MEMBER(mem), .PORT_LOW_POWER(lp),
    .ATTENTION_INDICATOR_OUT(attn), .INTERLOCK_OUT(il), .POWER_ENABLE_OUT(pe),
    .POWER_INDICATOR_OUT(pi), .PORT_RESET_OUT_N(rn),
    .PORT_ACTIVITY_OUT_N(act_n), .PORT_LINKUP_OUT_N(lnk), .CORE_ATTN_BTN_N(),
    .CORE_LATCH_N(), .CORE_PRESENCE_N(pres_n), .CORE_PWR_FAULT_N(),
    .CORE_PWR_GOOD_N());
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  function automatic smpm_exp_t build(input logic [3:0] m, logic [7:0] mn);
    smpm_exp_t x;
    x.pa = (m[3:1] == 3'b110) ? '0 : 48'h0000_0000_0001;
    x.pc = {16{4'h1}};
    x.pc[3:0] = 4'h2;
    if (m inside {4'h8, 4'hA}) x.pc[11:8] = 4'h0;
    if (m inside {4'h9, 4'hB}) x.pc[11:0] = 12'h210;
    if (m[3:1] == 3'b110) x.pc = {16{4'h5}};
    for (int i = 0; i < 8; i++) x.dm[2*i+:2] = {~mn[i], 1'b0};
    x.sp = {m, ~mn};
    x.te = {!(m inside {[4'h0:4'h1], [4'h8:4'hD]}),
            m inside {4'h1, 4'hA, 4'hB, 4'hD}};
    return x;
  endfunction : build
  task automatic cmp(input smpm_exp_t x, input logic first);
    logic [79:0] w;
    logic [15:0] nd;
    nd = ~x.dm;
    for (int p = 0; p < 16; p++)
      w[5*p+:5] = x.dm[p] ? 5'h00 : x.dm[p|1] ? 5'h08 : 5'h04;
    chk(PORT_CONTROL, x.pc);
    chk(PARTITION_CONTROL, x.pa);
    chk(dact, x.dm);
    chk(wid, w);
    chk(lp, x.dm);
    chk(act_n, x.dm);
    chk({il, pe, pi, rn, attn}, {nd, nd, nd, nd, nd});
    chk(lnk, x.dm);
    chk({swm, pmg}, x.sp);
    chk(pres_n, x.dm);
    chk({TEST_MODE, ee}, first ? x.te : {x.te[1], 1'b0});
  endtask : cmp
  task automatic cmp_link(input smpm_exp_t x);
    logic [15:0] en, mb;
    for (int p = 0; p < 16; p++) begin
      en[p] = !x.dm[p] && x.pc[4*p+:4] != 4'h0;
      mb[p] = en[p] && x.pc[4*p+:4] != 4'h5;
    end
    chk(lke, en);
    chk(mem, mb);
  endtask : cmp_link
  task automatic wt(input logic v);
    for (int i = 0; i < 60; i++) begin
      @(posedge CORE_CLK);
      if (CONFIG_DONE === v) return;
    end
    chk(80'h1, 80'h0);
    tally_and_finish();
  endtask : wt
  task automatic wr(input logic pt, input logic [3:0] i, input logic [3:0] d);
    @(posedge CORE_CLK);
    CFG_PART_WE <= pt;
    CFG_PORT_WE <= !pt;
    {CFG_PART_IDX, CFG_PORT_IDX, CFG_PART_DATA, CFG_PORT_DATA} <= {i, i, d[2:0], d};
    @(posedge CORE_CLK);
    CFG_PART_WE <= 1'b0;
    CFG_PORT_WE <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////
  // one pop per rise of done or per change of the control fields
  always @(posedge CORE_CLK) begin
    #1;
    if (lk) cmp_link(le);
    lk = 0;
    if (CONFIG_DONE === 1'b1 && (pd !== 1'b1 || PORT_CONTROL !== ppc ||
        PARTITION_CONTROL !== ppa)) begin
      if (q.size() == 0) begin
        chk(80'h1, 80'h0);
      end else begin
        le = q.pop_front();
        cmp(le, pd !== 1'b1);
        lk = 1;
      end
    end
    pd = CONFIG_DONE;
    ppc = PORT_CONTROL;
    ppa = PARTITION_CONTROL;
  end
  initial begin
    logic [7:0] r;
    void'($urandom(49));
    repeat (5) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    for (int m = 0; m < 16; m++) begin
      r = (8'($urandom()) & 8'hFE) | 8'(m[0]);
      e = build(m[3:0], r);
      q.push_back(e);
      @(posedge CORE_CLK);
      {md, mg, go} <= {m[3:0], r, 1'b1};
      @(posedge CORE_CLK);
      go <= 1'b0;
      wt(1'b0);
      wt(1'b1);
      // let wandering straps reach the core before the writes
      repeat (8) @(posedge CORE_CLK);
      if (!(m inside {[0:1], [8:11]})) begin
        e.pa[5:3] = 3'h1;
        q.push_back(e);
      end
      wr(1'b1, 4'h1, 4'h1);
      e.pc[7:4] = 4'h2;
      q.push_back(e);
      wr(1'b0, 4'h1, 4'h2);
    end
    repeat (4) @(posedge CORE_CLK);
    chk(80'(q.size()), 80'h0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
